// ===== slot_pm_pkg.sv
`default_nettype none
// ==========================================================
// shared constants and carriers
package slot_pm_pkg;

    // ======================================================
    // register indices, byte address is four times the index
    localparam logic [9:0] SLOT_CONTROL_IDX = 10'h058;
    localparam logic [9:0] SLOT_STATUS_IDX = 10'h05a;
    localparam logic [9:0] PM_CAP_IDX = 10'h070;
    localparam logic [9:0] WAKE_CONTROL_IDX = 10'h080;

    // ======================================================
    // slot control fixed fields
    localparam logic [5:0] SLOT_IRQ_ENABLES_VAL = 6'h00;
    localparam logic [1:0] ATTENTION_LED_VAL = 2'h3;
    localparam logic [1:0] POWER_LED_VAL = 2'h1;
    localparam logic [5:0] SLOT_CTL_UPPER_VAL = 6'h00;

    // ======================================================
    // slot status fixed fields
    localparam logic [5:0] SLOT_FLAGS_VAL = 6'h00;
    localparam logic PRESENCE_STATE_VAL = 1'b1;
    localparam logic INTERLOCK_STATE_VAL = 1'b0;
    localparam logic [7:0] SLOT_STS_UPPER_VAL = 8'h00;

    // ======================================================
    // power management capability fields
    localparam logic [7:0] CAP_ID_VAL = 8'h01;
    localparam logic [7:0] NEXT_CAP_PTR_VAL = 8'h00;
    localparam logic [2:0] CAP_VERSION_VAL = 3'h2;
    localparam logic WAKE_CLOCK_VAL = 1'b0;
    localparam logic PM_RSVD20_VAL = 1'b0;
    localparam logic SPECIAL_INIT_RESET = 1'b0;
    localparam int SPECIAL_INIT_BIT = 21;
    localparam logic [2:0] AUX_CURRENT_VAL = 3'h0;
    localparam logic [1:0] D1_D2_SUPPORT_VAL = 2'h0;
    localparam logic [4:0] WAKE_SUPPORT_VAL = 5'b11001;

    // ======================================================
    // wake control register fields
    localparam int UNLOCK_BIT = 0;
    localparam int D3_COLD_BIT = 8;
    localparam int DROPPED_BIT = 9;
    localparam logic UNLOCK_RESET = 1'b0;
    localparam logic DROPPED_RESET = 1'b0;

    // ======================================================
    // bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // assembled read image of the three capability words
    typedef struct packed {
        logic [15:0] slot_control;
        logic [15:0] slot_status;
        logic [31:0] power_mgmt_capabilities;
    } reg_image_t;

    // wake message path
    typedef struct packed {
        logic wake_msg;
        logic dropped;
    } wake_path_t;

endpackage
`default_nettype wire

// ===== reg_image.sv
`default_nettype none
// ==========================================================
// fixed read image of slot and power management registers
module reg_image (
    input wire logic special_init, // held device specific init bit
    output slot_pm_pkg::reg_image_t image // assembled words
);
    import slot_pm_pkg::*;

    // every field but one is a constant, so writes cannot touch them
    always_comb begin
        image.slot_control = {SLOT_CTL_UPPER_VAL, POWER_LED_VAL,
                              ATTENTION_LED_VAL, SLOT_IRQ_ENABLES_VAL};
        image.slot_status = {SLOT_STS_UPPER_VAL, INTERLOCK_STATE_VAL,
                             PRESENCE_STATE_VAL, SLOT_FLAGS_VAL};
        image.power_mgmt_capabilities = {WAKE_SUPPORT_VAL, D1_D2_SUPPORT_VAL,
                                         AUX_CURRENT_VAL, special_init,
                                         PM_RSVD20_VAL, WAKE_CLOCK_VAL,
                                         CAP_VERSION_VAL, NEXT_CAP_PTR_VAL,
                                         CAP_ID_VAL};
    end

endmodule // reg_image
`default_nettype wire

// ===== wake_gate.sv
`default_nettype none
// ==========================================================
// wake message forwarding gate
module wake_gate (
    input wire logic aclk, // core clock
    input wire logic aresetn, // synchronous reset, active low
    input wire logic wake_in, // one-cycle wake message from below
    input wire logic d3_cold, // port is in unpowered d3 cold
    output slot_pm_pkg::wake_path_t out // registered results
);
    import slot_pm_pkg::*;

    wake_path_t state_reg;
    wake_path_t state_next;

    // messages are swallowed in d3 cold; the system must route wake around us
    always_comb begin
        state_next.wake_msg = wake_in && !d3_cold;
        state_next.dropped = wake_in && d3_cold;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign out = state_reg;

endmodule // wake_gate
`default_nettype wire

// ===== slot_pm_regs.sv
// Added by the designer: register access over AXI4-Lite.
`default_nettype none
// Notes on behaviour
// - slot control interrupt enable bits 5:0 are read-only zero.
// - attention led control bits 7:6 read fixed 0x3.
// - power led control bits 9:8 read fixed 0x1.
// - slot control bits 10, 11 and 15:12 read-only zero.
// - slot status bits 5:0, 7 and 15:8 read-only zero.
// - slot status presence state bit 6 always reads one.
// - capability identifier bits 7:0 read 0x1.
// - next capability pointer bits 15:8 read 0x0.
// - capability version bits 18:16 read 0x2.
// - wake clock bit 19, bit 20, aux current 24:22 read zero.
// - special init bit 21 resets zero, writable only while unlocked.
// - d1 and d2 support bits 25, 26 read zero.
// - wake support bits 31:27 read fixed 0b11001.
// - wake messages are not forwarded while in d3 cold.
module slot_pm_regs #(
    parameter int ADDR_W = 12 // byte address width
) (
    input wire logic aclk, // core clock, 10 mhz
    input wire logic aresetn, // synchronous reset, active low
    // write address channel
    input wire logic awvalid, // write address valid
    output logic awready, // write address ready
    input wire logic [ADDR_W-1:0] awaddr, // write byte address
    input wire logic [2:0] awprot, // protection, unused
    // write data channel
    input wire logic wvalid, // write data valid
    output logic wready, // write data ready
    input wire logic [31:0] wdata, // write data
    input wire logic [3:0] wstrb, // byte lane strobes
    // write response channel
    output logic bvalid, // write response valid
    input wire logic bready, // write response ready
    output logic [1:0] bresp, // write response code
    // read address channel
    input wire logic arvalid, // read address valid
    output logic arready, // read address ready
    input wire logic [ADDR_W-1:0] araddr, // read byte address
    input wire logic [2:0] arprot, // protection, unused
    // read data channel
    output logic rvalid, // read data valid
    input wire logic rready, // read data ready
    output logic [31:0] rdata, // read data
    output logic [1:0] rresp, // read response code
    // wake message path
    input wire logic wake_in, // one-cycle wake message from a downstream port
    input wire logic d3_cold, // power controller reports d3 cold
    output logic wake_out // one-cycle forwarded wake message
);
    import slot_pm_pkg::*;

    // ======================================================
    // byte addresses derived from the register indices
    localparam logic [ADDR_W-1:0] SLOT_CONTROL_ADDR = ADDR_W'({SLOT_CONTROL_IDX, 2'b00});
    localparam logic [ADDR_W-1:0] SLOT_STATUS_ADDR = ADDR_W'({SLOT_STATUS_IDX, 2'b00});
    localparam logic [ADDR_W-1:0] PM_CAP_ADDR = ADDR_W'({PM_CAP_IDX, 2'b00});
    localparam logic [ADDR_W-1:0] WAKE_CONTROL_ADDR = ADDR_W'({WAKE_CONTROL_IDX, 2'b00});

    // ======================================================
    // module state
    typedef struct packed {
        // write halves waiting for their partner
        logic aw_held;
        logic [ADDR_W-1:0] aw_addr;
        logic w_held;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        // registered answers on the two response channels
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        // software visible fields
        logic special_init;
        logic unlock;
        logic dropped;
    } state_t;

    state_t state_reg;
    state_t state_next;

    reg_image_t image;
    wake_path_t wake_path;

    // ======================================================
    // fixed register image and wake gate
    reg_image u_image (
        .special_init(state_reg.special_init),
        .image(image)
    );

    wake_gate u_wake (
        .aclk(aclk),
        .aresetn(aresetn),
        .wake_in(wake_in),
        .d3_cold(d3_cold),
        .out(wake_path)
    );

    // ======================================================
    // handshake terms
    logic aw_fire;
    logic w_fire;
    logic have_aw;
    logic have_w;
    logic wr_do;
    logic ar_fire;
    logic [ADDR_W-1:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;

    // readies depend on state only, so a master cannot close a loop through them
    always_comb begin
        awready = !state_reg.aw_held && !state_reg.bvalid;
        wready = !state_reg.w_held && !state_reg.bvalid;
        arready = !state_reg.rvalid;
    end

    // address and data are each taken once, in either order
    always_comb begin
        aw_fire = awvalid && awready;
        w_fire = wvalid && wready;
        ar_fire = arvalid && arready;
        have_aw = state_reg.aw_held || aw_fire;
        have_w = state_reg.w_held || w_fire;
        wr_do = have_aw && have_w;
        wr_addr = state_reg.aw_held ? state_reg.aw_addr : awaddr;
        wr_data = state_reg.w_held ? state_reg.w_data : wdata;
        wr_strb = state_reg.w_held ? state_reg.w_strb : wstrb;
    end

    // ======================================================
    // address decode
    // word map, byte address is four times the index:
    //   slot control     fixed value in the low half word
    //   slot status      fixed value in the low half word
    //   capabilities     fixed except the special init bit
    //   wake control     unlock, live d3 cold level, sticky drop flag
    //   any other word   reads zero, drops writes, answers slverr
    logic wr_hit_fixed;
    logic wr_hit_pm;
    logic wr_hit_wake;
    logic wr_mapped;
    logic rd_mapped;
    logic [31:0] rd_word;
    logic [31:0] wake_word;

    // low two address bits are ignored, each register is one aligned word
    always_comb begin
        wr_hit_fixed = (wr_addr[ADDR_W-1:2] == SLOT_CONTROL_ADDR[ADDR_W-1:2])
                    || (wr_addr[ADDR_W-1:2] == SLOT_STATUS_ADDR[ADDR_W-1:2]);
        wr_hit_pm = wr_addr[ADDR_W-1:2] == PM_CAP_ADDR[ADDR_W-1:2];
        wr_hit_wake = wr_addr[ADDR_W-1:2] == WAKE_CONTROL_ADDR[ADDR_W-1:2];
        wr_mapped = wr_hit_fixed || wr_hit_pm || wr_hit_wake;
    end

    // wake control word shows lock, live power state and the drop flag
    always_comb begin
        wake_word = 32'h0000_0000;
        wake_word[UNLOCK_BIT] = state_reg.unlock;
        wake_word[D3_COLD_BIT] = d3_cold;
        wake_word[DROPPED_BIT] = state_reg.dropped;
    end

    // narrow registers sit in the low bits, upper bits read zero
    always_comb begin
        rd_mapped = 1'b1;
        unique case (araddr[ADDR_W-1:2])
            SLOT_CONTROL_ADDR[ADDR_W-1:2]: begin
                rd_word = {16'h0000, image.slot_control};
            end
            SLOT_STATUS_ADDR[ADDR_W-1:2]: begin
                rd_word = {16'h0000, image.slot_status};
            end
            PM_CAP_ADDR[ADDR_W-1:2]: begin
                rd_word = image.power_mgmt_capabilities;
            end
            WAKE_CONTROL_ADDR[ADDR_W-1:2]: begin
                rd_word = wake_word;
            end
            default: begin
                rd_word = 32'h0000_0000;
                rd_mapped = 1'b0;
            end
        endcase
    end

    // ======================================================
    // field write enables, each gated by the byte lane that holds it
    logic special_init_we;
    logic unlock_we;
    logic drop_clear;

    // the lock keeps a stray write from flipping the special init bit;
    // a capability write while locked still answers okay and changes nothing
    always_comb begin
        special_init_we = wr_do && wr_hit_pm && wr_strb[2] && state_reg.unlock;
        unlock_we = wr_do && wr_hit_wake && wr_strb[0];
        drop_clear = wr_do && wr_hit_wake && wr_strb[1] && wr_data[DROPPED_BIT];
    end

    // ======================================================
    // response codes
    logic [1:0] wr_resp;
    logic [1:0] rd_resp;

    // unmapped words answer slverr, so a stray pointer shows up at once
    always_comb begin
        wr_resp = wr_mapped ? RESP_OKAY : RESP_SLVERR;
        rd_resp = rd_mapped ? RESP_OKAY : RESP_SLVERR;
    end

    // ======================================================
    // next state
    always_comb begin
        state_next = state_reg;

        // hold a half of a write until its partner arrives
        if (aw_fire && !wr_do) begin
            state_next.aw_held = 1'b1;
            state_next.aw_addr = awaddr;
        end
        if (w_fire && !wr_do) begin
            state_next.w_held = 1'b1;
            state_next.w_data = wdata;
            state_next.w_strb = wstrb;
        end

        // write response stands until the master takes it
        if (state_reg.bvalid && bready) begin
            state_next.bvalid = 1'b0;
        end
        if (wr_do) begin
            state_next.aw_held = 1'b0;
            state_next.w_held = 1'b0;
            state_next.bvalid = 1'b1;
            state_next.bresp = wr_resp;
        end

        // only the special init bit of the capability word takes writes
        if (special_init_we) begin
            state_next.special_init = wr_data[SPECIAL_INIT_BIT];
        end
        // slot words have nothing writable, a write there changes nothing
        if (wr_do && wr_hit_fixed) begin
            state_next.special_init = state_reg.special_init;
        end

        // lock control
        if (unlock_we) begin
            state_next.unlock = wr_data[UNLOCK_BIT];
        end

        // drop flag: write one clears, a new drop in the same cycle wins
        if (drop_clear) begin
            state_next.dropped = 1'b0;
        end
        if (wake_path.dropped) begin
            state_next.dropped = 1'b1;
        end

        // read data stands until the master takes it
        if (state_reg.rvalid && rready) begin
            state_next.rvalid = 1'b0;
        end
        if (ar_fire) begin
            state_next.rvalid = 1'b1;
            state_next.rdata = rd_word;
            state_next.rresp = rd_resp;
        end
    end

    // ======================================================
    // state register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            // handshakes clear, software fields take their named reset values
            state_reg <= '0;
            state_reg.special_init <= SPECIAL_INIT_RESET;
            state_reg.unlock <= UNLOCK_RESET;
            state_reg.dropped <= DROPPED_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    // ======================================================
    // outputs
    // write response
    assign bvalid = state_reg.bvalid;
    assign bresp = state_reg.bresp;

    // read data
    assign rvalid = state_reg.rvalid;
    assign rdata = state_reg.rdata;
    assign rresp = state_reg.rresp;

    // wake message, registered inside the gate
    assign wake_out = wake_path.wake_msg;

    // protection bits carry no meaning here
    logic unused_prot;
    assign unused_prot = ^{awprot, arprot};

endmodule // slot_pm_regs
`default_nettype wire

// ===== slot_pm_regs_properties.sv
`default_nettype none
// ==========================================================
// protocol and value checks on the register bank ports
module slot_pm_regs_properties #(
    parameter int ADDR_W = 12 // byte address width
) (
    input wire logic aclk, // core clock
    input wire logic aresetn, // synchronous reset, active low
    input wire logic arvalid, // read address valid
    input wire logic arready, // read address ready
    input wire logic [ADDR_W-1:0] araddr, // read byte address
    input wire logic rvalid, // read data valid
    input wire logic [31:0] rdata, // read data
    input wire logic [1:0] rresp, // read response
    input wire logic bvalid, // write response valid
    input wire logic bready, // write response ready
    input wire logic wake_in, // wake message in
    input wire logic d3_cold, // d3 cold level
    input wire logic wake_out // forwarded wake message
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // ======================================================
    // masked read value one cycle after the read address is taken
    property rd_word(logic [9:0] idx, logic [31:0] m, logic [31:0] v);
        arvalid && arready && araddr[11:2] == idx |=> rvalid && (rdata & m) == v;
    endproperty

    chk_slot_ctl_val:
        assert property (rd_word(10'h058, 32'hffffffff, 32'h000001c0)) else $error("slot control value");
    chk_slot_sts_val:
        assert property (rd_word(10'h05a, 32'hffffffff, 32'h00000040)) else $error("slot status value");
    chk_cap_id_ptr:
        assert property (rd_word(10'h070, 32'h0000ffff, 32'h00000001)) else $error("capability id");
    chk_cap_version:
        assert property (rd_word(10'h070, 32'h00070000, 32'h00020000)) else $error("capability version");
    chk_cap_zero_fields:
        assert property (rd_word(10'h070, 32'h01d80000, 32'h0)) else $error("capability zero fields");
    chk_d1_d2_off:
        assert property (rd_word(10'h070, 32'h06000000, 32'h0)) else $error("d1 d2 support");
    chk_wake_support:
        assert property (rd_word(10'h070, 32'hf8000000, 32'hc8000000)) else $error("wake support field");

    // ======================================================
    // wake forwarding, gated off while unpowered
    chk_wake_fwd:
        assert property (wake_in && !d3_cold |=> wake_out) else $error("wake not forwarded");
    chk_wake_block:
        assert property (wake_in && d3_cold |=> !wake_out) else $error("wake forwarded in d3 cold");
    chk_wake_spur:
        assert property (!wake_in |=> !wake_out) else $error("spurious wake");

    cover property (rvalid && rresp == 2'h2);
    cover property (wake_in && d3_cold);
    cover property (bvalid && bready);
endmodule // slot_pm_regs_properties

bind slot_pm_regs slot_pm_regs_properties #(.ADDR_W(ADDR_W)) u_chk (.aclk, .aresetn, .arvalid, .arready,
    .araddr, .rvalid, .rdata, .rresp, .bvalid, .bready, .wake_in, .d3_cold, .wake_out);
`default_nettype wire

// ===== slot_and_pm_capability_regs_test.sv
`default_nettype none
// ==========================================================
// self-checking bench for the slot and power management bank
module slot_and_pm_capability_regs_test;
    timeunit 1ns;
    timeprecision 1ns;
    import slot_pm_pkg::*;
    localparam logic [11:0] A_SC = {SLOT_CONTROL_IDX, 2'h0};
    localparam logic [11:0] A_SS = {SLOT_STATUS_IDX, 2'h0};
    localparam logic [11:0] A_PM = {PM_CAP_IDX, 2'h0};
    localparam logic [11:0] A_WC = {WAKE_CONTROL_IDX, 2'h0};
    localparam logic [31:0] PM_V = 32'hc8020001;
    localparam logic [31:0] SI = 32'h00200000;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic wake_in = 0, d3_cold = 0, awready, wready, bvalid, arready, rvalid, wake_out;
    logic [11:0] awaddr = 12'h0, araddr = 12'h0;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0] wstrb = 4'h0;
    logic [1:0] bresp, rresp;
    int fail_count = 0, tests_run = 0;
    logic [33:0] rq[$];
    logic [1:0] wq[$];
    logic kq[$];

    initial forever #50 aclk = ~aclk;

    slot_pm_regs #(.ADDR_W(12)) i_dut (.aclk, .aresetn, .awvalid, .awready, .awaddr, .awprot(3'h0), .wvalid,
        .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .arprot(3'h0),
        .rvalid, .rready, .rdata, .rresp, .wake_in, .d3_cold, .wake_out);

    // ======================================================
    // comparison and closing
    task automatic check(input logic [33:0] seen, input logic [33:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // ======================================================
    // bus master tasks, every change right after a rising edge
    task automatic do_reset();
        aresetn <= 0;
        repeat (12) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er);
        rq.push_back({er, exp});
        arvalid <= 1;
        araddr <= a;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 0;
        rready <= 1;
        do @(posedge aclk); while (rvalid !== 1'b1);
        rready <= 0;
    endtask

    // address and data offered together, each released once taken
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
        logic ad;
        logic dd;
        ad = 0;
        dd = 0;
        wq.push_back(er);
        awvalid <= 1;
        awaddr <= a;
        wvalid <= 1;
        wdata <= d;
        wstrb <= s;
        while (!(ad && dd)) begin
            @(posedge aclk);
            if (!ad && awready === 1'b1) begin ad = 1; awvalid <= 0; end
            if (!dd && wready === 1'b1) begin dd = 1; wvalid <= 0; end
        end
        // raised only once both halves are taken, so two writes in a row never toggle it in one step
        bready <= 1;
        do @(posedge aclk); while (bvalid !== 1'b1);
        bready <= 0;
    endtask

    // ======================================================
    // monitors take the oldest expectation as each result appears
    always @(posedge aclk) begin
        if (rvalid === 1'b1 && rready === 1'b1) check({rresp, rdata}, rq.pop_front());
        if (bvalid === 1'b1 && bready === 1'b1) check({32'h0, bresp}, {32'h0, wq.pop_front()});
    end
    // sampled mid-cycle so the registered pulse has settled
    always @(negedge aclk) begin
        if (kq.size() > 0) check({33'h0, wake_out}, {33'h0, kq.pop_front()});
    end

    initial begin
        #500000;
        fail_count++;
        finish_test();
    end

    // ======================================================
    // main sequence
    initial begin
        logic [31:0] r;
        logic prev;
        r = $urandom(44);
        do_reset();
        rd(A_SC, 32'h000001c0, RESP_OKAY);
        rd(A_SS, 32'h00000040, RESP_OKAY);
        rd(A_PM, PM_V, RESP_OKAY);
        rd(A_WC, 32'h0, RESP_OKAY);
        rd(12'h004, 32'h0, RESP_SLVERR);
        wr(12'h004, 32'hffffffff, 4'hf, RESP_SLVERR);
        $display("test reset_values done");
        // random writes to the fixed words must leave them alone while locked
        for (int i = 0; i < 4; i++) begin
            r = $urandom;
            wr(A_SC, r, 4'hf, RESP_OKAY);
            wr(A_SS, ~r, 4'hf, RESP_OKAY);
            wr(A_PM, r | SI, 4'hf, RESP_OKAY);
            rd(A_SC, 32'h000001c0, RESP_OKAY);
            rd(A_SS, 32'h00000040, RESP_OKAY);
            rd(A_PM, PM_V, RESP_OKAY);
        end
        $display("test read_only_writes done");
        wr(A_WC, 32'h1, 4'h1, RESP_OKAY);
        wr(A_PM, SI, 4'h4, RESP_OKAY);
        rd(A_PM, PM_V | SI, RESP_OKAY);
        wr(A_PM, 32'h0, 4'hb, RESP_OKAY);
        rd(A_PM, PM_V | SI, RESP_OKAY);
        wr(A_WC, 32'h0, 4'h1, RESP_OKAY);
        wr(A_PM, 32'h0, 4'hf, RESP_OKAY);
        rd(A_PM, PM_V | SI, RESP_OKAY);
        do_reset();
        rd(A_PM, PM_V, RESP_OKAY);
        $display("test special_init done");
        // random wake traffic, expectation lags the drive by one cycle
        prev = 0;
        for (int i = 0; i < 200; i++) begin
            @(posedge aclk);
            r = $urandom;
            wake_in <= r[0];
            d3_cold <= r[1];
            if (i > 0) kq.push_back(prev);
            prev = r[0] && !r[1];
        end
        @(posedge aclk);
        wake_in <= 0;
        kq.push_back(prev);
        @(posedge aclk);
        d3_cold <= 1;
        wake_in <= 1;
        @(posedge aclk);
        wake_in <= 0;
        // let the sticky drop flag land before the read samples it
        @(posedge aclk);
        rd(A_WC, 32'h00000300, RESP_OKAY);
        wr(A_WC, 32'h00000200, 4'h2, RESP_OKAY);
        d3_cold <= 0;
        rd(A_WC, 32'h0, RESP_OKAY);
        $display("test wake_gate done");
        repeat (4) @(posedge aclk);
        finish_test();
    end
endmodule // slot_and_pm_capability_regs_test
`default_nettype wire
